//--- inc/pts_pkg.sv
// package for the peak tracking switch control block
package pts_pkg;

    // mode sequence, gray coded along the normal path
    typedef enum logic [2:0] {
        PTS_RESET   = 3'b000,
        PTS_POWERON = 3'b001,
        PTS_OFFSET  = 3'b011,
        PTS_CALIB   = 3'b010,
        PTS_RUN     = 3'b110
    } pts_mode_t;

    // timing
    localparam int PTS_CLK_MHZ       = 125;
    localparam int PTS_PO_TIME_US    = 2300;
    localparam int PTS_PO_CYCLES     = (PTS_PO_TIME_US * PTS_CLK_MHZ) / 2;
    localparam int PTS_OFS_CYCLES    = (PTS_PO_TIME_US * PTS_CLK_MHZ) / 2;

    // calibration ends on this rising output edge
    localparam int PTS_CAL_EDGES     = 3;

    // data widths and field defaults
    localparam int PTS_SIG_W         = 12;
    localparam int PTS_GAIN_W        = 4;
    localparam int PTS_OFS_W         = 12;
    localparam logic [PTS_GAIN_W-1:0] PTS_GAIN_MAX  = 4'hf;
    localparam logic [PTS_SIG_W-1:0]  PTS_HYST_DEF  = 12'h040;
    localparam logic [PTS_SIG_W-1:0]  PTS_AMP_HIGH  = 12'h700;
    localparam logic [PTS_SIG_W-1:0]  PTS_AMP_LOW   = 12'h380;
    localparam logic [PTS_OFS_W-1:0]  PTS_OFS_RESET = 12'h000;
    localparam logic                  PTS_POS_LEVEL = 1'b1;

    // one detected peak as handed to the gain and offset logic
    typedef struct packed {
        logic                 valid;
        logic                 upper;
        logic [PTS_SIG_W-1:0] value;
    } pts_peak_t;

endpackage

//--- hdl/pts_peak_hold.sv
// peak follower with hysteresis switching decision
`timescale 1ns/1ns

module pts_peak_hold
    import pts_pkg::*;
#(
    parameter int W = PTS_SIG_W
)
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         enable,
    input  wire logic [W-1:0] sample,
    input  wire logic [W-1:0] operate_hysteresis,
    input  wire logic [W-1:0] release_hysteresis,
    output logic              tracking_up,
    output pts_peak_t         peak
);

    logic         tracking_up_ff;
    logic         nxt_tracking_up;
    logic [W-1:0] held_ff;
    logic [W-1:0] nxt_held;
    pts_peak_t    peak_ff;
    pts_peak_t    nxt_peak;
    logic [W:0]   drop;
    logic [W:0]   rise;

    // elaboration check on the sample width
    if (W < 4 || W > PTS_SIG_W)
    begin
        $error("pts_peak_hold: width out of range");
    end

    assign drop = {1'b0, held_ff} - {1'b0, sample};
    assign rise = {1'b0, sample} - {1'b0, held_ff};

    always_comb
    begin
        nxt_tracking_up = tracking_up_ff;
        nxt_held        = held_ff;
        nxt_peak        = '0;
        if (enable)
        begin
            if (tracking_up_ff)
            begin
                // (R3) follow upward
                if (sample > held_ff)
                    nxt_held = sample;
                // (R4) operate switch
                else if (!drop[W] && drop[W-1:0] >= operate_hysteresis)
                begin
                    nxt_tracking_up = 1'b0;
                    nxt_peak        = '{valid: 1'b1, upper: 1'b1, value: held_ff};
                    nxt_held        = sample;
                end
            end
            else
            begin
                if (sample < held_ff)
                    nxt_held = sample;
                // (R5) release switch
                else if (!rise[W] && rise[W-1:0] >= release_hysteresis)
                begin
                    nxt_tracking_up = 1'b1;
                    nxt_peak        = '{valid: 1'b1, upper: 1'b0, value: held_ff};
                    nxt_held        = sample;
                end
            end
        end
        else
            nxt_held = sample;
    end

    // (R6) peak held without decay
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            tracking_up_ff <= 1'b1;
            held_ff        <= '0;
            peak_ff        <= '0;
        end
        else
        begin
            tracking_up_ff <= nxt_tracking_up;
            held_ff        <= nxt_held;
            peak_ff        <= nxt_peak;
        end
    end

    assign tracking_up = tracking_up_ff;
    assign peak        = peak_ff;

    property p_peak_dir;
        @(posedge clk) disable iff (!rstn)
        peak.valid |-> (tracking_up != peak.upper);
    endproperty
    a_peak_dir: assert property (p_peak_dir) else $error("peak direction mismatch"); // (R17)

    property p_hold_max;
        @(posedge clk) disable iff (!rstn)
        (enable && tracking_up_ff && sample > held_ff) |=> (held_ff == $past(sample));
    endproperty
    a_hold_max: assert property (p_hold_max) else $error("upper peak not followed"); // (R3)

endmodule

//--- hdl/pts_switch_ctrl.sv
// top of the peak tracking switch control block
`timescale 1ns/1ns

// Overview of operation
// (R1) output held released high while the device initializes after power-up
// (R2) initial offset cancellation completes before any output transition is allowed
// (R3) tracker follows a rising signal and holds its highest value
// (R4) fall below upper peak by operate hysteresis toggles output, tracks down
// (R5) rise above lower peak by release hysteresis toggles output, tracks up
// (R6) peaks held digitally with no decay, valid down to standstill
// (R7) calibration measures peak-to-peak amplitude and sets the optimal gain
// (R8) offset converter readjusted after every gain change to keep signal centred
// (R9) tracking and toggling work normally during calibration
// (R10) calibration exit tolerates extra output edges
// (R11) after calibration, running mode gives one transition per detected peak
// (R12) running mode may lower gain but never raise it
// (R13) offset compensation active in calibration and running modes
// (R14) undervoltage resets device, output back to power-on state
// (R15) calibration done by third rising output edge
// (R16) mode machine: reset, power-on, offset adjust, calibration, running
// (R17) direction and output registered, one toggle per peak
module pts_switch_ctrl
    import pts_pkg::*;
#(
    parameter int PO_CYCLES  = PTS_PO_CYCLES,
    parameter int OFS_CYCLES = PTS_OFS_CYCLES,
    parameter int CAL_EDGES  = PTS_CAL_EDGES
)
(
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  undervoltage,
    input  wire logic [PTS_SIG_W-1:0]  processed_differential_signal,
    input  wire logic [PTS_SIG_W-1:0]  operate_hysteresis,
    input  wire logic [PTS_SIG_W-1:0]  release_hysteresis,
    output logic                       out_o,
    output logic                       out_oe,
    output logic [PTS_GAIN_W-1:0]      gain_control,
    output logic [PTS_OFS_W-1:0]       offset_compensation,
    output pts_mode_t                  mode
);

    // elaboration check on the timing parameters
    if (PO_CYCLES < 1 || OFS_CYCLES < 1 || CAL_EDGES < 1 || CAL_EDGES > 15)
    begin
        $error("pts_switch_ctrl: parameter out of range");
    end

    // ------------------------------------------------------------
    // pin synchroniser for the undervoltage comparator
    // ------------------------------------------------------------
    logic [2:0] uv_sync_ff;
    logic       uv_ff;
    logic       nxt_uv;

    always_comb
    begin
        nxt_uv = uv_ff;
        if (uv_sync_ff[1] == uv_sync_ff[2])
            nxt_uv = uv_sync_ff[1];
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            uv_sync_ff <= '0;
            uv_ff      <= 1'b0;
        end
        else
        begin
            uv_sync_ff <= {uv_sync_ff[1:0], undervoltage};
            uv_ff      <= nxt_uv;
        end
    end

    // ------------------------------------------------------------
    // mode sequence
    // ------------------------------------------------------------
    pts_mode_t   mode_ff;
    pts_mode_t   nxt_mode;
    logic [31:0] tmr_ff;
    logic [31:0] nxt_tmr;
    logic [3:0]  rise_cnt_ff;
    logic [3:0]  nxt_rise_cnt;
    logic        out_ff;
    logic        nxt_out;
    logic        tracking_up;
    pts_peak_t   peak;
    logic        track_en;

    assign track_en = (mode_ff == PTS_CALIB) || (mode_ff == PTS_RUN);

    always_comb
    begin
        nxt_mode     = mode_ff;
        nxt_tmr      = tmr_ff;
        nxt_rise_cnt = rise_cnt_ff;
        case (mode_ff)
            // (R16) ordered sequence
            PTS_RESET:
            begin
                nxt_tmr  = '0;
                nxt_mode = PTS_POWERON;
            end
            PTS_POWERON:
            begin
                nxt_tmr = tmr_ff + 32'h1;
                if (tmr_ff >= 32'(PO_CYCLES - 1))
                begin
                    nxt_tmr  = '0;
                    nxt_mode = PTS_OFFSET;
                end
            end
            // (R2) offset step before switching
            PTS_OFFSET:
            begin
                nxt_tmr = tmr_ff + 32'h1;
                if (tmr_ff >= 32'(OFS_CYCLES - 1))
                begin
                    nxt_tmr      = '0;
                    nxt_rise_cnt = '0;
                    nxt_mode     = PTS_CALIB;
                end
            end
            // (R15) exit on nth rising edge
            PTS_CALIB:
            begin
                if (peak.valid && !peak.upper)
                begin
                    nxt_rise_cnt = rise_cnt_ff + 4'h1;
                    // (R10) extra edges tolerated
                    if (rise_cnt_ff >= 4'(CAL_EDGES - 1))
                        nxt_mode = PTS_RUN;
                end
            end
            // (R11) running until reset
            PTS_RUN:
                nxt_mode = PTS_RUN;
            default:
                nxt_mode = PTS_RESET;
        endcase
        // (R14) undervoltage resets
        if (uv_ff)
            nxt_mode = PTS_RESET;
    end

    // ------------------------------------------------------------
    // output level
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_out = out_ff;
        // (R1) released high until tracking
        if (!track_en || uv_ff)
            nxt_out = PTS_POS_LEVEL;
        // (R17) one toggle per peak
        else if (peak.valid)
            nxt_out = ~out_ff;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            mode_ff     <= PTS_RESET;
            tmr_ff      <= '0;
            rise_cnt_ff <= '0;
            out_ff      <= PTS_POS_LEVEL;
        end
        else
        begin
            mode_ff     <= nxt_mode;
            tmr_ff      <= nxt_tmr;
            rise_cnt_ff <= nxt_rise_cnt;
            out_ff      <= nxt_out;
        end
    end

    // (R9) tracking live in calibration and running
    pts_peak_hold #(
        .W (PTS_SIG_W)
    ) u_peak (
        .clk                (clk),
        .rstn               (rstn && !uv_ff),
        .enable             (track_en),
        .sample             (processed_differential_signal),
        .operate_hysteresis (operate_hysteresis),
        .release_hysteresis (release_hysteresis),
        .tracking_up        (tracking_up),
        .peak               (peak)
    );

    // ------------------------------------------------------------
    // gain and offset control
    // ------------------------------------------------------------
    logic [PTS_GAIN_W-1:0] gain_ff;
    logic [PTS_GAIN_W-1:0] nxt_gain;
    logic [PTS_OFS_W-1:0]  ofs_ff;
    logic [PTS_OFS_W-1:0]  nxt_ofs;
    logic [PTS_SIG_W-1:0]  hi_ff;
    logic [PTS_SIG_W-1:0]  nxt_hi;
    logic [PTS_SIG_W-1:0]  amp;
    logic [PTS_SIG_W:0]    mid;
    logic [PTS_SIG_W-1:0]  centre;

    // hi_ff holds the last upper peak; a lower peak closes one swing
    assign amp    = (hi_ff > peak.value) ? hi_ff - peak.value : '0;
    assign mid    = ({1'b0, hi_ff} + {1'b0, peak.value}) >> 1;
    assign centre = {1'b1, {(PTS_SIG_W-1){1'b0}}};

    always_comb
    begin
        nxt_gain = gain_ff;
        nxt_ofs  = ofs_ff;
        nxt_hi   = hi_ff;
        if (mode_ff == PTS_OFFSET)
            nxt_ofs = PTS_OFS_RESET;
        if (track_en && peak.valid && peak.upper)
            nxt_hi = peak.value;
        if (track_en && peak.valid && !peak.upper)
        begin
            // (R13) continuous offset drift correction
            if (mid[PTS_SIG_W-1:0] > centre)
                nxt_ofs = ofs_ff + 12'h001;
            else if (mid[PTS_SIG_W-1:0] < centre)
                nxt_ofs = ofs_ff - 12'h001;
            // (R7) calibrate gain from amplitude
            if (mode_ff == PTS_CALIB && amp < PTS_AMP_LOW && gain_ff != PTS_GAIN_MAX)
                nxt_gain = gain_ff + 4'h1;
            // (R12) running mode only lowers
            else if (amp > PTS_AMP_HIGH && gain_ff != '0)
                nxt_gain = gain_ff - 4'h1;
            // (R8) recentre after gain step
            if (nxt_gain != gain_ff)
                nxt_ofs = ofs_ff - PTS_SIG_W'(mid[PTS_SIG_W-1:0] - centre);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn || uv_ff)
        begin
            gain_ff <= PTS_GAIN_MAX;
            ofs_ff  <= PTS_OFS_RESET;
            hi_ff   <= '0;
        end
        else
        begin
            gain_ff <= nxt_gain;
            ofs_ff  <= nxt_ofs;
            hi_ff   <= nxt_hi;
        end
    end

    // open drain: drive low when output level is low
    assign out_o               = 1'b0;
    assign out_oe              = ~out_ff;
    assign gain_control        = gain_ff;
    assign offset_compensation = ofs_ff;
    assign mode                = mode_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_pos_high;
        @(posedge clk) disable iff (!rstn)
        (mode_ff == PTS_POWERON || mode_ff == PTS_OFFSET) |-> !out_oe;
    endproperty
    a_pos_high: assert property (p_pos_high) else $error("output low before calibration"); // (R1)

    property p_no_switch_early;
        @(posedge clk) disable iff (!rstn)
        (mode_ff == PTS_OFFSET) |=> !$fell(out_ff);
    endproperty
    a_no_switch_early: assert property (p_no_switch_early) else $error("switch during offset adjust"); // (R2)

    property p_toggle;
        @(posedge clk) disable iff (!rstn)
        (track_en && !uv_ff && peak.valid) |=> (out_ff != $past(out_ff));
    endproperty
    a_toggle: assert property (p_toggle) else $error("peak without toggle"); // (R11)

    property p_no_raise;
        @(posedge clk) disable iff (!rstn)
        (mode_ff == PTS_RUN && $past(mode_ff) == PTS_RUN) |-> !(gain_ff > $past(gain_ff));
    endproperty
    a_no_raise: assert property (p_no_raise) else $error("gain raised in running mode"); // (R12)

    property p_uv_reset;
        @(posedge clk) disable iff (!rstn)
        uv_ff |=> (mode_ff == PTS_RESET) ##1 out_ff;
    endproperty
    a_uv_reset: assert property (p_uv_reset) else $error("undervoltage did not reset"); // (R14)

    property p_cal_exit;
        @(posedge clk) disable iff (!rstn)
        (mode_ff == PTS_CALIB && !uv_ff && peak.valid && !peak.upper && rise_cnt_ff == 4'(CAL_EDGES - 1))
        |=> (mode_ff == PTS_RUN);
    endproperty
    a_cal_exit: assert property (p_cal_exit) else $error("calibration did not end"); // (R15)

    property p_seq;
        @(posedge clk) disable iff (!rstn)
        (mode_ff == PTS_CALIB && $past(mode_ff) != PTS_CALIB) |-> ($past(mode_ff) == PTS_OFFSET);
    endproperty
    a_seq: assert property (p_seq) else $error("calibration entered out of order"); // (R16)

    property p_ofs_in_track;
        @(posedge clk) disable iff (!rstn)
        (!track_en && mode_ff != PTS_OFFSET && !uv_ff) |=> $stable(ofs_ff);
    endproperty
    a_ofs_in_track: assert property (p_ofs_in_track) else $error("offset moved while idle"); // (R13)

    c_run:    cover property (@(posedge clk) disable iff (!rstn) mode_ff == PTS_RUN);
    c_gain:   cover property (@(posedge clk) disable iff (!rstn) mode_ff == PTS_RUN && $fell(gain_ff[0]));
    c_uv_run: cover property (@(posedge clk) disable iff (!rstn) mode_ff == PTS_RUN && uv_ff);

endmodule

//--- tb/pts_host_model.sv
// host side of the speed line: pull-up on the open-drain pin and a rising edge counter
`timescale 1ns/1ns

module pts_host_model
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       out_o,
    input  wire logic       out_oe,
    output logic            pin,
    output logic [7:0]      rise_cnt
);
    logic       pin_ff;
    logic [7:0] rise_ff;
    logic [7:0] nxt_rise;

    // the pull-up wins whenever the device releases the line
    assign pin      = out_oe ? out_o : 1'b1;
    assign rise_cnt = rise_ff;

    always_comb
    begin
        nxt_rise = rise_ff;
        if (!rstn)
            nxt_rise = 8'h00;
        else if (pin && !pin_ff)
            nxt_rise = rise_ff + 8'h01;
    end

    always_ff @(posedge clk)
    begin
        pin_ff  <= pin;
        rise_ff <= nxt_rise;
    end
endmodule

//--- tb/testbench.sv
// self-checking bench for the peak tracking switch control block
`timescale 1ns/1ns

module testbench
    import pts_pkg::*;
;
    localparam int PO  = 8;
    localparam int OFS = 8;
    typedef struct packed {logic lvl; int due;} pts_exp_t;

    logic                  clk          = 1'b0;
    logic                  rstn         = 1'b0;
    logic                  undervoltage = 1'b0;
    logic [PTS_SIG_W-1:0]  sig          = 12'h800;
    logic [PTS_SIG_W-1:0]  op_h         = PTS_HYST_DEF;
    logic [PTS_SIG_W-1:0]  rel_h        = PTS_HYST_DEF;
    logic [PTS_SIG_W-1:0]  held         = 12'h800;
    logic                  up           = 1'b1;
    logic                  active       = 1'b0;
    logic                  pin_q        = 1'b1;
    logic                  out_o;
    logic                  out_oe;
    logic                  pin;
    logic [PTS_GAIN_W-1:0] gain;
    logic [PTS_GAIN_W-1:0] gain_q;
    logic [PTS_OFS_W-1:0]  ofs;
    pts_mode_t             mode;
    pts_mode_t             mode_q;
    logic [7:0]            rises;
    int                    fails        = 0;
    int                    n_tests      = 0;
    int                    cyc          = 0;
    int                    seed         = 32'h71f62d71;
    pts_exp_t              expq[$];

    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    pts_switch_ctrl #(.PO_CYCLES(PO), .OFS_CYCLES(OFS), .CAL_EDGES(PTS_CAL_EDGES)) dut
    (
        .clk(clk), .rstn(rstn), .undervoltage(undervoltage), .processed_differential_signal(sig),
        .operate_hysteresis(op_h), .release_hysteresis(rel_h), .out_o(out_o), .out_oe(out_oe),
        .gain_control(gain), .offset_compensation(ofs), .mode(mode)
    );

    pts_host_model host
    (
        .clk(clk), .rstn(rstn), .out_o(out_o), .out_oe(out_oe), .pin(pin), .rise_cnt(rises)
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wrap_up();
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one sample per cycle; the tracker model notes each toggle it predicts
    task automatic drive(input logic [11:0] v);
        @(posedge clk);
        #1;
        sig = v;
        if (active)
        begin
            if (up && held >= v && held - v >= op_h)
            begin
                expq.push_back('{1'b0, cyc + 2});
                up   = 1'b0;
                held = v;
            end
            else if (!up && v >= held && v - held >= rel_h)
            begin
                expq.push_back('{1'b1, cyc + 2});
                up   = 1'b1;
                held = v;
            end
            else if (up ? v > held : v < held)
                held = v;
        end
    endtask

    task automatic ramp(input logic [11:0] tgt, input int maxstep);
        logic [11:0] v;
        int          st;
        v = sig;
        while (v != tgt)
        begin
            st = 1 + ($unsigned($random(seed)) % maxstep);
            if (v < tgt)
                v = (tgt - v > st) ? v + 12'(st) : tgt;
            else
                v = (v - tgt > st) ? v - 12'(st) : tgt;
            drive(v);
        end
    endtask

    function automatic pts_mode_t step_mode(input pts_mode_t m);
        case (m)
            PTS_RESET:   return PTS_POWERON;
            PTS_POWERON: return PTS_OFFSET;
            PTS_OFFSET:  return PTS_CALIB;
            default:     return PTS_RUN;
        endcase
    endfunction

    // start-up with a wildly moving input: the pin must stay released
    task automatic wait_calib();
        pts_mode_t last;
        int        n;
        active = 1'b0;
        last   = mode;
        n      = 0;
        while (mode !== PTS_CALIB && n < 200)
        begin
            drive(n < 12 ? (n % 2 ? 12'hc00 : 12'h400) : 12'h800);
            n++;
            if (mode !== last)
            begin
                chk("mode order", 12'(step_mode(last)), 12'(mode));
                last = mode;
            end
        end
        chk("power-on time", 12'h001, 12'(n >= PO + OFS && n <= PO + OFS + 8));
        repeat (4) drive(12'h800);
        held   = 12'h800;
        up     = 1'b1;
        active = 1'b1;
    endtask

    // ----------------------------------------
    // output watcher
    // ----------------------------------------
    always @(posedge clk)
    begin
        pts_exp_t e;
        #2;
        if (pin !== pin_q)
        begin
            if (expq.size() == 0)
                chk("unexpected toggle", 12'(pin_q), 12'(pin));
            else
            begin
                e = expq.pop_front();
                chk("pin level", 12'(e.lvl), 12'(pin));
                chk("pin cycle", 12'(e.due), 12'(cyc));
            end
        end
        if (mode === PTS_RUN && mode_q === PTS_RUN && gain !== gain_q)
            chk("run gain step", 12'(gain_q - 4'h1), 12'(gain));
        pin_q  = pin;
        gain_q = gain;
        mode_q = mode;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        chk("reset mode", 12'(PTS_RESET), 12'(mode));
        chk("reset pin", 12'h001, 12'(pin));
        chk("reset gain", 12'(PTS_GAIN_MAX), 12'(gain));
        chk("reset offset", 12'(PTS_OFS_RESET), 12'(ofs));
        rstn = 1'b1;
        wait_calib();
        ramp(12'ha00, 16);
        drive(12'ha00 - op_h + 12'h001);
        drive(12'ha00);
        drive(12'ha00 - op_h);
        ramp(12'h600, 16);
        repeat (300) drive(12'h600);
        drive(12'h600 + rel_h - 12'h001);
        drive(12'h600);
        ramp(12'ha00, 16);
        ramp(12'h600, 16);
        ramp(12'ha00, 16);
        chk("mode at two edges", 12'(PTS_CALIB), 12'(mode));
        ramp(12'h600, 16);
        ramp(12'ha00, 16);
        chk("rising edges", 12'h003, 12'(rises));
        chk("mode at third edge", 12'(PTS_RUN), 12'(mode));
        chk("calibrated gain", 12'(PTS_GAIN_MAX), 12'(gain));
        ramp(12'h200, 32);
        ramp(12'he00, 32);
        chk("reduced gain", 12'(PTS_GAIN_MAX - 4'h1), 12'(gain));
        chk("offset moved", 12'h001, 12'(ofs !== PTS_OFS_RESET));
        repeat (4)
        begin
            ramp(12'h780, 32);
            ramp(12'h880, 32);
        end
        chk("gain kept", 12'(PTS_GAIN_MAX - 4'h1), 12'(gain));
        repeat (12)
        begin
            op_h  = 12'h010 + 12'($unsigned($random(seed)) % 64);
            rel_h = 12'h010 + 12'($unsigned($random(seed)) % 64);
            ramp(12'h880 + 12'($unsigned($random(seed)) % 768), 64);
            ramp(12'h780 - 12'($unsigned($random(seed)) % 768), 64);
        end
        ramp(12'h900, 64);
        undervoltage = 1'b1;
        active       = 1'b0;
        // hold the upper peak so no toggle races the undervoltage reset
        for (int i = 0; i < 10 && mode !== PTS_RESET; i++)
            drive(12'h900);
        repeat (3) drive(12'h800);
        chk("uv mode", 12'(PTS_RESET), 12'(mode));
        chk("uv pin", 12'h001, 12'(pin));
        chk("uv gain", 12'(PTS_GAIN_MAX), 12'(gain));
        chk("uv offset", 12'(PTS_OFS_RESET), 12'(ofs));
        undervoltage = 1'b0;
        wait_calib();
        ramp(12'ha00, 16);
        ramp(12'h600, 16);
        ramp(12'ha00, 16);
        repeat (4) drive(12'ha00);
        chk("pending toggles", 12'h000, 12'(expq.size()));
        wrap_up();
    end

    initial
    begin
        #(8 * 40000);
        fails++;
        wrap_up();
    end
endmodule
